// [bench/mpc_core_chk.sv]
// Checker: concurrent properties on the mode protection core ports
module mpc_core_chk
	import mpc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Decoder and data path
	input wire logic op_valid_i,
	input wire logic [3:0] op_code_i,
	input wire logic [15:0] saved_psw_i,
	input wire logic mem_req_i,
	input wire logic mem_ifetch_i,
	input wire logic mem_prev_i,
	input wire logic mem_stack_i,
	input wire logic [15:0] mem_va_i,
	// Design outputs
	input wire logic mem_req_o,
	input wire logic [12:0] mem_offset_o,
	input wire logic [1:0] mem_space_mode_o,
	input wire logic mem_dspace_o,
	input wire logic mem_abort_o,
	input wire logic [15:0] psw_o,
	input wire logic pc_load_en_o,
	input wire logic bus_reset_o,
	input wire logic halt_trap_o
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	wire logic kern = psw_o[15:14] == MODE_KERNEL;
	wire logic [1:0] prev_m = psw_o[13:12];
	wire logic [12:0] va_off = mem_va_i[12:0];
	sequence s_op(c);
		op_valid_i && op_code_i == c;
	endsequence
	sequence s_req;
		mem_req_i;
	endsequence
	a_halt_trap: assert property (s_op(MPC_OP_HALT) ##0 !kern |=> halt_trap_o)
		else $error("halt outside kernel did not trap");
	a_reset_idle: assert property (s_op(MPC_OP_BUS_RESET) ##0 !kern |=> !bus_reset_o)
		else $error("bus reset pulsed outside kernel");
	a_reset_kern: assert property (s_op(MPC_OP_BUS_RESET) ##0 kern |=> bus_reset_o)
		else $error("kernel bus reset missing");
	a_return_psw: assert property (op_valid_i && kern &&
		(op_code_i == MPC_OP_RTI || op_code_i == MPC_OP_RTT)
		|=> pc_load_en_o && psw_o == $past(saved_psw_i)) else $error("return did not restore");
	a_abort_excl: assert property (mem_abort_o |-> !mem_req_o)
		else $error("aborted transfer still requested");
	a_out_cause: assert property (mem_req_o || mem_abort_o |-> $past(mem_req_i))
		else $error("transfer without request");
	a_space_route: assert property (s_req ##0 (!mem_prev_i || mem_ifetch_i || mem_stack_i)
		|=> !mem_req_o || mem_dspace_o == !$past(mem_ifetch_i)) else $error("wrong space");
	a_user_only: assert property (s_req ##0 psw_o[15:14] == MODE_USER
		|=> !mem_req_o || mem_space_mode_o == MODE_USER) else $error("user left user map");
	a_prev_mode: assert property (s_req ##0 mem_prev_i && !mem_ifetch_i && !mem_stack_i
		##0 psw_o[15:14] != MODE_USER
		|=> !mem_req_o || mem_space_mode_o == $past(prev_m)) else $error("wrong previous map");
	a_offset_pass: assert property (s_req |=> !mem_req_o || mem_offset_o == $past(va_off))
		else $error("offset mismatch");
	a_bad_mode: assert property (s_req ##0 psw_o[15:14] == MODE_BAD |=> mem_abort_o)
		else $error("invalid mode not aborted");
endmodule

// [bench/mpc_core_tb_top.sv]
// Testbench: mode protection core over APB, decoder and memory ports
module mpc_core_tb_top
	import mpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic sys_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, op_valid_i = 0;
	logic mem_req_i = 0, mem_write_i = 0, mem_ifetch_i = 0, mem_prev_i = 0, mem_stack_i = 0;
	logic [3:0] op_code_i = 0;
	logic [11:0] paddr_i = 0;
	logic [15:0] op_data_i = 0, saved_pc_i = 0, saved_psw_i = 0, mem_va_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd, snap;
	logic pready_o, pslverr_o, mem_req_o, mem_write_o, mem_dspace_o, mem_abort_o, err, irq_s;
	logic [15:0] mem_reloc_o, psw_o, pc_load_o;
	logic [12:0] mem_offset_o;
	logic [1:0] mem_space_mode_o, stack_sel_o;
	logic pc_load_en_o, regset_o, halt_o, bus_reset_o, halt_trap_o, irq_o;
	logic [3:0] pulses;
	logic [20:0] mres;
	int n_fail = 0, n_tests = 0, n_xfer, n_write, n_dsp;
	always #2.5 sys_clk_i = ~sys_clk_i;
	mpc_core mpc_core_i (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .op_valid_i, .op_code_i, .op_data_i, .saved_pc_i,
		.saved_psw_i, .mem_req_i, .mem_write_i, .mem_ifetch_i, .mem_prev_i, .mem_stack_i, .mem_va_i,
		.mem_req_o, .mem_write_o, .mem_reloc_o, .mem_offset_o, .mem_space_mode_o, .mem_dspace_o,
		.mem_abort_o, .psw_o, .pc_load_o, .pc_load_en_o, .stack_sel_o, .regset_o, .halt_o,
		.bus_reset_o, .halt_trap_o, .irq_o);
	mpc_mem_model mpc_mem_model_i (.sys_clk_i, .mem_req_i(mem_req_o), .mem_write_i(mem_write_o),
		.mem_dspace_i(mem_dspace_o), .n_xfer_o(n_xfer), .n_write_o(n_write), .n_dspace_o(n_dsp));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1;
		penable_i <= 0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1;
		do @(posedge sys_clk_i); while (pready_o !== 1'h1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 0;
		penable_i <= 0;
		@(negedge sys_clk_i);
		irq_s = irq_o;
		@(posedge sys_clk_i);
	endtask
	task automatic op(input logic [3:0] c, input logic [15:0] d);
		op_valid_i <= 1;
		op_code_i <= c;
		op_data_i <= d;
		@(posedge sys_clk_i);
		op_valid_i <= 0;
		@(negedge sys_clk_i);
		pulses = {pc_load_en_o, bus_reset_o, halt_trap_o, halt_o};
		snap = {psw_o, pc_load_o};
		@(posedge sys_clk_i);
	endtask
	task automatic mem(input logic i, w, p, input logic [3:0] c, input logic [15:0] va);
		mem_req_i <= 1;
		mem_ifetch_i <= i;
		mem_write_i <= w;
		mem_prev_i <= p;
		mem_stack_i <= !p && c != 4'h0;
		op_valid_i <= p;
		op_code_i <= c;
		mem_va_i <= va;
		@(posedge sys_clk_i);
		mem_req_i <= 0;
		op_valid_i <= 0;
		@(negedge sys_clk_i);
		mres = {mem_abort_o, mem_req_o, mem_dspace_o, mem_space_mode_o, mem_reloc_o};
		@(posedge sys_clk_i);
	endtask
	function automatic logic [31:0] mw(logic [1:0] m, logic [2:0] pg, logic [1:0] ac,
		logic [15:0] r);
		return {1'h1, 4'h0, pg, 2'h0, m, 2'h0, ac, r};
	endfunction
	function automatic logic [20:0] ok(logic ds, logic [1:0] m, logic [15:0] r);
		return {2'h1, ds, m, r};
	endfunction
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_n_i <= 1;
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chk({psw_o, halt_o, irq_o}, 0);
		@(posedge sys_clk_i);
		apb(0, 12'h018, 0);
		chk(err, 1);
		chk(rd, 0);
		apb(1, REG_MAP_D, mw(MODE_KERNEL, 3'h0, ACC_RW, 16'h0100));
		apb(1, REG_MAP_I, mw(MODE_KERNEL, 3'h0, ACC_RO, 16'h0200));
		apb(1, REG_MAP_D, mw(MODE_USER, 3'h1, ACC_RO, 16'h0300));
		apb(1, REG_MAP_I, mw(MODE_USER, 3'h1, ACC_RW, 16'h0400));
		mem(0, 0, 0, MPC_OP_NONE, 16'h0010);
		chk(mres, ok(1, MODE_KERNEL, 16'h0100));
		mem(1, 0, 0, MPC_OP_NONE, 16'h0020);
		chk(mres, ok(0, MODE_KERNEL, 16'h0200));
		mem(0, 0, 0, MPC_OP_NONE, 16'h4010);
		chk(mres[20:19], 2'h2);
		// Mask bits enable: reset leaves every source disabled
		apb(0, REG_ISTAT, 0);
		chk({irq_s, rd[3:0]}, 5'h01);
		apb(1, REG_IMASK, 32'h1);
		chk(irq_s, 1);
		apb(1, REG_ISTAT, 32'h1);
		chk(irq_s, 0);
		apb(1, REG_IMASK, 0);
		chk(irq_s, 0);
		apb(1, REG_PSW, 32'h3000);
		mem(0, 0, 1, MPC_OP_FROM_PREV_I, 16'h2000);
		chk(mres, ok(0, MODE_USER, 16'h0400));
		mem(0, 0, 1, MPC_OP_FROM_PREV_D, 16'h2000);
		chk(mres, ok(1, MODE_USER, 16'h0300));
		mem(0, 1, 1, MPC_OP_TO_PREV_I, 16'h2002);
		chk(mres, ok(0, MODE_USER, 16'h0400));
		mem(0, 1, 1, MPC_OP_TO_PREV_D, 16'h2002);
		chk(mres[20:19], 2'h2);
		mem(0, 1, 0, MPC_OP_TO_PREV_D, 16'h0010);
		chk(mres, ok(1, MODE_KERNEL, 16'h0100));
		// Address constant of a cross-space move stays in current I space
		mem(1, 0, 1, MPC_OP_FROM_PREV_D, 16'h0020);
		chk(mres, ok(0, MODE_KERNEL, 16'h0200));
		op(MPC_OP_BUS_RESET, 0);
		chk(pulses, 4'h4);
		op(MPC_OP_SPL, 16'h5);
		chk(snap[23:21], 3'h5);
		op(MPC_OP_HALT, 0);
		chk(pulses, 4'h1);
		apb(1, REG_PSW, 32'h3000);
		apb(0, REG_STATE, 0);
		chk(rd[4:0], {1'h0, MODE_KERNEL, MODE_USER});
		saved_psw_i <= 16'hf800;
		saved_pc_i <= 16'h1234;
		op(MPC_OP_RTI, 0);
		chk(snap, 32'hf8001234);
		chk(pulses[3], 1);
		chk({stack_sel_o, regset_o}, 3'h7);
		op(MPC_OP_BUS_RESET, 0);
		chk(pulses, 0);
		op(MPC_OP_SPL, 16'h7);
		op(MPC_OP_SET_PSW, 0);
		chk(snap[31:16], 16'hf800);
		op(MPC_OP_HALT, 0);
		chk(pulses, 4'h2);
		mem(0, 0, 1, MPC_OP_FROM_PREV_D, 16'h2000);
		chk(mres, ok(1, MODE_USER, 16'h0300));
		mem(0, 1, 0, MPC_OP_NONE, 16'h2004);
		chk(mres[20:19], 2'h2);
		mem(0, 0, 0, MPC_OP_NONE, 16'h0010);
		chk(mres[20:19], 2'h2);
		apb(1, REG_PSW, 0);
		saved_psw_i <= 16'h3000;
		op(MPC_OP_RTT, 0);
		chk(snap[31:16], 16'h3000);
		apb(1, REG_PSW, 32'h8000);
		mem(0, 0, 0, MPC_OP_NONE, 16'h0010);
		chk(mres[20:19], 2'h2);
		apb(0, REG_ISTAT, 0);
		chk(rd[3:0], 4'hf);
		chk(n_xfer, 8);
		chk(n_write, 2);
		chk(n_dsp, 4);
		report_and_stop;
	end
	// Whole sequence needs about a hundred cycles; this leaves ample margin
	initial begin
		#20000;
		n_fail++;
		report_and_stop;
	end
endmodule

bind mpc_core mpc_core_chk mpc_core_chk_i (.sys_clk_i, .rst_n_i, .op_valid_i, .op_code_i,
	.saved_psw_i, .mem_req_i, .mem_ifetch_i, .mem_prev_i, .mem_stack_i, .mem_va_i, .mem_req_o,
	.mem_offset_o,
	.mem_space_mode_o, .mem_dspace_o, .mem_abort_o, .psw_o, .pc_load_en_o, .bus_reset_o,
	.halt_trap_o);

// [bench/mpc_mem_model.sv]
// Partner model: memory behind the mapping unit, counting accepted transfers
module mpc_mem_model (
	// Clock
	input wire logic sys_clk_i,
	// Transfers from the core
	input wire logic mem_req_i,
	input wire logic mem_write_i,
	input wire logic mem_dspace_i,
	// Bookkeeping for the bench
	output int n_xfer_o,
	output int n_write_o,
	output int n_dspace_o
);
	// ----------------------------------------
	// Transfer accounting
	// ----------------------------------------
	initial begin
		n_xfer_o = 0;
		n_write_o = 0;
		n_dspace_o = 0;
	end
	// Aborted transfers never reach memory, so they are not counted
	always @(posedge sys_clk_i) begin
		if (mem_req_i) begin
			n_xfer_o <= n_xfer_o + 1;
			n_write_o <= n_write_o + int'(mem_write_i);
			n_dspace_o <= n_dspace_o + int'(mem_dspace_i);
		end
	end
endmodule

// [hw/mpc_access_check.sv]
// Access checker: applies page access code to one transfer
module mpc_access_check
	import mpc_pkg::*;
(
	// Request
	input wire logic req_i,
	input wire logic write_i,
	input wire logic [1:0] acc_i,
	// Verdict
	output logic abort_nr_o,
	output logic abort_ro_o,
	output logic grant_o
);
	always_comb begin
		abort_nr_o = req_i && (acc_i == ACC_NONRES || acc_i == ACC_RSVD);
		abort_ro_o = req_i && write_i && acc_i == ACC_RO;
		grant_o = req_i && !abort_nr_o && !abort_ro_o;
	end
endmodule

// [hw/mpc_core.sv]
// Top: mode tracking, cross-space moves, returns, privilege and access steering
// ----------------------------------------
// Overview of operation
// - Previous mode lives in status bits 13:12
// - Cross-space moves link current stack, previous space
// - Address constants fetched through current space
// - Each mode has 16-bit I and D spaces
// - Four cross-space instructions decoded
// - Returns restore saved PC and status
// - User mode maps only through user space
// - Access code held beside relocation, non-resident code
// - Read-only pages refuse writes
// - Fetches use I map, data uses D map except MPC_OP_TO_PREV_I and MPC_OP_FROM_PREV_I final operands
// - Privileged operations act only in kernel
// - Outside kernel, reset and priority do nothing
// - Outside kernel, halt traps instead
// - Current mode bits 15:14 pick map, stack
// - Bit 11 selects general register set
// - Non-resident page access aborts instruction
module mpc_core
	import mpc_pkg::*;
#(
	parameter int RELOC_W = 16
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Instruction step from the decoder
	input wire logic op_valid_i,
	input wire logic [3:0] op_code_i,
	input wire logic [15:0] op_data_i,
	input wire logic [15:0] saved_pc_i,
	input wire logic [15:0] saved_psw_i,
	// Memory transfer request from the data path
	input wire logic mem_req_i,
	input wire logic mem_write_i,
	input wire logic mem_ifetch_i,
	input wire logic mem_prev_i,
	input wire logic mem_stack_i,
	input wire logic [15:0] mem_va_i,
	// Towards mapping unit and memory
	output logic mem_req_o,
	output logic mem_write_o,
	output logic [RELOC_W-1:0] mem_reloc_o,
	output logic [12:0] mem_offset_o,
	output logic [1:0] mem_space_mode_o,
	output logic mem_dspace_o,
	output logic mem_abort_o,
	// Processor state
	output logic [15:0] psw_o,
	output logic [15:0] pc_load_o,
	output logic pc_load_en_o,
	output logic [1:0] stack_sel_o,
	output logic regset_o,
	output logic halt_o,
	output logic bus_reset_o,
	output logic halt_trap_o,
	output logic irq_o
);
	// ----------------------------------------
	// Status word and decoded fields
	// ----------------------------------------
	logic [15:0] psw;
	logic [1:0] cur_mode;
	logic [1:0] prev_mode;
	logic kernel;
	mpc_op_e op;

	assign cur_mode = psw[PSW_CUR_HI:PSW_CUR_LO];
	assign prev_mode = psw[PSW_PRV_HI:PSW_PRV_LO];
	assign kernel = cur_mode == MODE_KERNEL;
	assign op = mpc_op_e'(op_code_i);

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	logic apb_wr;
	logic apb_rd;
	logic hit_psw;
	logic hit_map_i;
	logic hit_map_d;
	logic hit_istat;
	logic hit_imask;
	logic hit_state;
	logic hit_any;

	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign apb_rd = psel_i && penable_i && !pwrite_i;
	assign pready_o = 1'b1;

	always_comb begin
		hit_psw = 1'b0;
		hit_map_i = 1'b0;
		hit_map_d = 1'b0;
		hit_istat = 1'b0;
		hit_imask = 1'b0;
		hit_state = 1'b0;
		if (paddr_i == REG_PSW) begin
			hit_psw = 1'b1;
		end else if (paddr_i == REG_MAP_I) begin
			hit_map_i = 1'b1;
		end else if (paddr_i == REG_MAP_D) begin
			hit_map_d = 1'b1;
		end else if (paddr_i == REG_ISTAT) begin
			hit_istat = 1'b1;
		end else if (paddr_i == REG_IMASK) begin
			hit_imask = 1'b1;
		end else if (paddr_i == REG_STATE) begin
			hit_state = 1'b1;
		end
	end
	assign hit_any = hit_psw | hit_map_i | hit_map_d | hit_istat | hit_imask | hit_state;
	assign pslverr_o = psel_i && penable_i && !hit_any;

	// ----------------------------------------
	// Privilege decisions
	// ----------------------------------------
	logic priv_ok;
	logic do_return;

	assign priv_ok = op_valid_i && kernel;
	assign do_return = op_valid_i && (op == MPC_OP_RTI || op == MPC_OP_RTT);

	// Status word: returns load saved word; privileged writes only in kernel
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			psw <= PSW_RESET;
		end else if (do_return) begin
			// Kernel is trusted to force saved previous bits to user
			psw <= saved_psw_i;
		end else if (priv_ok && op == MPC_OP_SET_PSW) begin
			psw <= op_data_i;
		end else if (priv_ok && op == MPC_OP_SPL) begin
			psw[PSW_PRI_HI:PSW_PRI_LO] <= op_data_i[PSW_PRI_HI-PSW_PRI_LO:0];
		end else if (apb_wr && hit_psw) begin
			psw <= pwdata_i[15:0];
		end
	end

	// PC load for returns, one-cycle pulse
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pc_load_en_o <= 1'b0;
			pc_load_o <= '0;
		end else begin
			pc_load_en_o <= do_return;
			if (do_return) begin
				pc_load_o <= saved_pc_i;
			end
		end
	end

	// Halt, bus reset, halt trap
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			halt_o <= 1'b0;
			bus_reset_o <= 1'b0;
			halt_trap_o <= 1'b0;
		end else begin
			bus_reset_o <= priv_ok && op == MPC_OP_BUS_RESET;
			halt_trap_o <= op_valid_i && !kernel && op == MPC_OP_HALT;
			if (priv_ok && op == MPC_OP_HALT) begin
				halt_o <= 1'b1;
			end else if (apb_wr && hit_psw) begin
				halt_o <= 1'b0;
			end
		end
	end

	assign psw_o = psw;
	assign stack_sel_o = cur_mode;
	assign regset_o = psw[PSW_REGSET];

	// ----------------------------------------
	// Space steering
	// ----------------------------------------
	logic use_prev;
	logic [1:0] space_mode;
	logic dspace;

	// Only the final operand of a cross-space move uses previous mode
	assign use_prev = mem_prev_i && !mem_ifetch_i && !mem_stack_i;
	always_comb begin
		space_mode = use_prev ? prev_mode : cur_mode;
		if (cur_mode == MODE_USER) begin
			space_mode = MODE_USER;
		end
		dspace = !mem_ifetch_i;
		if (use_prev && (op == MPC_OP_TO_PREV_I || op == MPC_OP_FROM_PREV_I)) begin
			dspace = 1'b0;
		end else if (use_prev && (op == MPC_OP_TO_PREV_D || op == MPC_OP_FROM_PREV_D)) begin
			dspace = 1'b1;
		end
	end

	// ----------------------------------------
	// Page maps
	// ----------------------------------------
	logic [RELOC_W-1:0] reloc_i;
	logic [RELOC_W-1:0] reloc_d;
	logic [1:0] acc_i;
	logic [1:0] acc_d;
	logic [1:0] acc_sel;
	logic [2:0] page;
	logic abort_nr;
	logic abort_ro;
	logic bad_mode;
	logic grant;

	assign page = mem_va_i[PAGE_HI:PAGE_LO];

	mpc_page_map #(.RELOC_W(RELOC_W)) u_map_i (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(apb_wr && hit_map_i),
		.wr_mode_i(pwdata_i[MAP_MODE_BIT+1:MAP_MODE_BIT]),
		.wr_page_i(pwdata_i[MAP_PAGE_BIT+2:MAP_PAGE_BIT]),
		.wr_reloc_i(pwdata_i[RELOC_W-1:0]),
		.wr_acc_i(pwdata_i[MAP_ACC_BIT+1:MAP_ACC_BIT]),
		.rd_mode_i(space_mode),
		.rd_page_i(page),
		.rd_reloc_o(reloc_i),
		.rd_acc_o(acc_i)
	);

	mpc_page_map #(.RELOC_W(RELOC_W)) u_map_d (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(apb_wr && hit_map_d),
		.wr_mode_i(pwdata_i[MAP_MODE_BIT+1:MAP_MODE_BIT]),
		.wr_page_i(pwdata_i[MAP_PAGE_BIT+2:MAP_PAGE_BIT]),
		.wr_reloc_i(pwdata_i[RELOC_W-1:0]),
		.wr_acc_i(pwdata_i[MAP_ACC_BIT+1:MAP_ACC_BIT]),
		.rd_mode_i(space_mode),
		.rd_page_i(page),
		.rd_reloc_o(reloc_d),
		.rd_acc_o(acc_d)
	);

	assign acc_sel = dspace ? acc_d : acc_i;
	assign bad_mode = mem_req_i && space_mode == MODE_BAD;

	mpc_access_check u_check (
		.req_i(mem_req_i && !bad_mode),
		.write_i(mem_write_i),
		.acc_i(acc_sel),
		.abort_nr_o(abort_nr),
		.abort_ro_o(abort_ro),
		.grant_o(grant)
	);

	// Registered request towards memory; aborts kill the transfer
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			mem_req_o <= 1'b0;
			mem_write_o <= 1'b0;
			mem_reloc_o <= '0;
			mem_offset_o <= '0;
			mem_space_mode_o <= MODE_KERNEL;
			mem_dspace_o <= 1'b0;
			mem_abort_o <= 1'b0;
		end else begin
			mem_req_o <= grant;
			mem_write_o <= mem_write_i && grant;
			mem_reloc_o <= dspace ? reloc_d : reloc_i;
			mem_offset_o <= mem_va_i[PAGE_LO-1:0];
			mem_space_mode_o <= space_mode;
			mem_dspace_o <= dspace;
			mem_abort_o <= abort_nr | abort_ro | bad_mode;
		end
	end

	// ----------------------------------------
	// Interrupt status and mask
	// ----------------------------------------
	logic [EV_W-1:0] istat;
	logic [EV_W-1:0] imask;
	logic [EV_W-1:0] ev;

	always_comb begin
		ev = '0;
		ev[EV_ABORT_NR] = abort_nr;
		ev[EV_ABORT_RO] = abort_ro;
		ev[EV_HALT_TRAP] = op_valid_i && !kernel && op == MPC_OP_HALT;
		ev[EV_BAD_MODE] = bad_mode;
	end

	// New events win over a write-one clear in the same cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			istat <= '0;
			imask <= '0;
		end else begin
			istat <= (istat & ~((apb_wr && hit_istat) ? pwdata_i[EV_W-1:0] : '0)) | ev;
			if (apb_wr && hit_imask) begin
				imask <= pwdata_i[EV_W-1:0];
			end
		end
	end
	assign irq_o = |(istat & imask);

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			prdata_o <= '0;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= '0;
			if (hit_psw) begin
				prdata_o <= {16'h0000, psw};
			end else if (hit_istat) begin
				prdata_o <= {{(32-EV_W){1'b0}}, istat};
			end else if (hit_imask) begin
				prdata_o <= {{(32-EV_W){1'b0}}, imask};
			end else if (hit_state) begin
				prdata_o <= {27'h0000000, halt_o, cur_mode, prev_mode};
			end
		end
	end
endmodule

// [hw/mpc_page_map.sv]
// Per-mode page map: relocation and access code for one address space
module mpc_page_map
	import mpc_pkg::*;
#(
	parameter int NMODES = 4,
	parameter int RELOC_W = 16
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [1:0] wr_mode_i,
	input wire logic [2:0] wr_page_i,
	input wire logic [RELOC_W-1:0] wr_reloc_i,
	input wire logic [1:0] wr_acc_i,
	// Lookup port
	input wire logic [1:0] rd_mode_i,
	input wire logic [2:0] rd_page_i,
	output logic [RELOC_W-1:0] rd_reloc_o,
	output logic [1:0] rd_acc_o
);
	logic [RELOC_W-1:0] reloc [NMODES*NPAGES];
	logic [1:0] acc [NMODES*NPAGES];
	logic [4:0] wr_idx;
	logic [4:0] rd_idx;

	assign wr_idx = {wr_mode_i, wr_page_i};
	assign rd_idx = {rd_mode_i, rd_page_i};

	// Access code stored beside relocation; reset leaves every page non-resident
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			for (int k = 0; k < NMODES*NPAGES; k++) begin
				acc[k] <= ACC_NONRES;
				reloc[k] <= '0;
			end
		end else if (wr_en_i) begin
			acc[wr_idx] <= wr_acc_i;
			reloc[wr_idx] <= wr_reloc_i;
		end
	end

	assign rd_reloc_o = reloc[rd_idx];
	assign rd_acc_o = acc[rd_idx];
endmodule

// [hw/mpc_pkg.sv]
// Package: constants, encodings and register map of the mode protection block
package mpc_pkg;
	// ----------------------------------------
	// Status word fields
	// ----------------------------------------
	localparam int PSW_CUR_HI = 15;
	localparam int PSW_CUR_LO = 14;
	localparam int PSW_PRV_HI = 13;
	localparam int PSW_PRV_LO = 12;
	localparam int PSW_REGSET = 11;
	localparam int PSW_PRI_HI = 7;
	localparam int PSW_PRI_LO = 5;
	localparam int VA_W = 16;
	localparam int PAGE_HI = 15;
	localparam int PAGE_LO = 13;
	localparam int NPAGES = 8;

	// ----------------------------------------
	// Mode encodings
	// ----------------------------------------
	localparam logic [1:0] MODE_KERNEL = 2'h0;
	localparam logic [1:0] MODE_SUPER = 2'h1;
	localparam logic [1:0] MODE_BAD = 2'h2;
	localparam logic [1:0] MODE_USER = 2'h3;

	// ----------------------------------------
	// Page access codes
	// ----------------------------------------
	localparam logic [1:0] ACC_NONRES = 2'h0;
	localparam logic [1:0] ACC_RO = 2'h1;
	localparam logic [1:0] ACC_RSVD = 2'h2;
	localparam logic [1:0] ACC_RW = 2'h3;

	// ----------------------------------------
	// Operation codes from the decoder
	// ----------------------------------------
	typedef enum logic [3:0] {
		MPC_OP_NONE,
		MPC_OP_TO_PREV_I,
		MPC_OP_TO_PREV_D,
		MPC_OP_FROM_PREV_I,
		MPC_OP_FROM_PREV_D,
		MPC_OP_RTI,
		MPC_OP_RTT,
		MPC_OP_HALT,
		MPC_OP_BUS_RESET,
		MPC_OP_SPL,
		MPC_OP_SET_PSW
	} mpc_op_e;

	// ----------------------------------------
	// APB register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] REG_PSW = 12'h000;
	localparam logic [11:0] REG_MAP_I = 12'h004;
	localparam logic [11:0] REG_MAP_D = 12'h008;
	localparam logic [11:0] REG_ISTAT = 12'h00c;
	localparam logic [11:0] REG_IMASK = 12'h010;
	localparam logic [11:0] REG_STATE = 12'h014;
	localparam int MAP_ACC_BIT = 16;
	localparam int MAP_MODE_BIT = 20;
	localparam int MAP_PAGE_BIT = 24;
	localparam int MAP_WE_BIT = 31;
	localparam logic [15:0] PSW_RESET = 16'h0000;

	// ----------------------------------------
	// Event bits
	// ----------------------------------------
	localparam int EV_ABORT_NR = 0;
	localparam int EV_ABORT_RO = 1;
	localparam int EV_HALT_TRAP = 2;
	localparam int EV_BAD_MODE = 3;
	localparam int EV_W = 4;
endpackage
